// file: src/mpo_top.sv
// Heat meter pulse output unit with AHB-Lite register access
`include "mpo_map.svh"

// What this block does
// - Both C outputs alike, both D outputs alike, all from one code.
// - C drives the first output of both slots, D the second output of both slots.
// - Configuration code resets to register pulses of 32 ms.
// - Codes 80 and 82 forward flow pulses one for one.
// - Code 80: C follows first flow, D second flow, 3,9 ms.
// - Code 82: only C active, 3,9 ms per first flow pulse.
// - Code 73: C gives one 5 ms pulse per four flow pulses.
// - Code 83: C gives one 22 ms pulse per four flow pulses.
// - Register pulses are 10, 32 or 100 ms for codes 94, 95, 96.
// - Each pair counts one register, fixed at delivery.
// - Default pair sources follow the meter function table.
// - One register pulse per least displayed digit step.
// - Pulses gathered per interval, sent as a burst each integration.
// - Code 99: commands open or close each pair.
// - Commanded state stored, readable, restored after power-on.
// - Interval 32 s normal, 8 s or 2 s fast, 2-64 s adaptive.
module mpo_top
	import mpo_pkg::*;
#(
	parameter int        TICK_CYCLES = `MPO_TICK_US * `MPO_CLK_MHZ,
	parameter mpo_func_e METER_FUNC  = FUNC_HEAT,
	parameter int        PW          = 16
) (
	// Clock, reset and enable
	input  wire logic        CLOCK_I,
	input  wire logic        NRST_I,
	input  wire logic        CE_I,
	// AHB-Lite slave
	input  wire logic        HSEL_I,
	input  wire logic [31:0] HADDR_I,
	input  wire logic [1:0]  HTRANS_I,
	input  wire logic        HWRITE_I,
	input  wire logic [2:0]  HSIZE_I,
	input  wire logic [31:0] HWDATA_I,
	input  wire logic        HREADY_I,
	output logic      [31:0] HRDATA_O,
	output logic             HREADYOUT_O,
	output logic             HRESP_O,
	// Meter events
	input  wire mpo_evt_s    MTR_EVT_I,
	// Non-volatile store of the commanded state
	input  wire logic [1:0]  NVM_RDATA_I,
	output logic             NVM_WR_O,
	output logic      [1:0]  NVM_WDATA_O,
	// Pulse outputs, high means closed
	output logic             SLOT1_FIRST_OUTPUT_O,
	output logic             SLOT2_FIRST_OUTPUT_O,
	output logic             SLOT1_SECOND_OUTPUT_O,
	output logic             SLOT2_SECOND_OUTPUT_O
);

	localparam int TCW = $clog2(TICK_CYCLES + 1);
	localparam int ICW = 20;

	if (TICK_CYCLES < 1) begin : g_bad_tick
		$error("TICK_CYCLES must be at least one");
	end
	if (PW < 4) begin : g_bad_pw
		$error("PW too narrow for pending counts");
	end

	// ==========================================================
	// Helper functions
	function automatic mpo_mode_e mode_of(input logic [6:0] c);
		case (c)
			`MPO_CODE_TX2, `MPO_CODE_TX1:       mode_of = MODE_TX;
			`MPO_CODE_DIV5, `MPO_CODE_DIV22:    mode_of = MODE_DIV;
			`MPO_CODE_REG10, `MPO_CODE_REG32,
			`MPO_CODE_REG100:                   mode_of = MODE_REG;
			`MPO_CODE_CTRL:                     mode_of = MODE_CTRL;
			default:                            mode_of = MODE_OFF;
		endcase
	endfunction

	function automatic logic [15:0] us_ticks(input int us);
		us_ticks = 16'((us + `MPO_TICK_US - 1) / `MPO_TICK_US);
	endfunction

	function automatic logic [15:0] width_of(input logic [6:0] c);
		case (c)
			`MPO_CODE_TX2, `MPO_CODE_TX1: width_of = us_ticks(`MPO_W_TX_US);
			`MPO_CODE_DIV5:    width_of = us_ticks(`MPO_W_DIV5_US);
			`MPO_CODE_DIV22:   width_of = us_ticks(`MPO_W_DIV22_US);
			`MPO_CODE_REG10:   width_of = us_ticks(`MPO_W_REG10_US);
			`MPO_CODE_REG32:   width_of = us_ticks(`MPO_W_REG32_US);
			`MPO_CODE_REG100:  width_of = us_ticks(`MPO_W_REG100_US);
			default:           width_of = us_ticks(`MPO_W_REG32_US);
		endcase
	endfunction

	function automatic mpo_src_e src_of(input mpo_func_e f, input int p);
		case (f)
			FUNC_HEAT:      src_of = (p == 0) ? SRC_HEAT : SRC_VOL;
			FUNC_HEAT_COOL: src_of = (p == 0) ? SRC_HEAT : SRC_COOL;
			FUNC_COOL:      src_of = (p == 0) ? SRC_COOL : SRC_VOL;
			default:        src_of = SRC_VOL;
		endcase
	endfunction

	// ==========================================================
	// Register state
	logic [6:0]  code;
	mpo_integ_e  integ_mode;
	logic [6:0]  adapt_secs;
	logic [1:0]  ctrl_state;
	logic        restored;
	logic        code_clr;
	mpo_mode_e   mode;
	logic [15:0] width;
	logic [1:0]  gen_busy;
	logic [1:0]  gen_out;
	logic [1:0]  pair_out;

	assign mode  = mode_of(code);
	assign width = width_of(code);

	// ==========================================================
	// AHB-Lite slave, zero wait states, always OKAY
	logic        addr_ok;
	logic        wr_q;
	logic [31:0] waddr_q;
	logic [31:0] rd_mux;
	logic        wr_cfg;
	logic        wr_integ;
	logic        wr_ctrl;
	logic [1:0]  next_ctrl;

	assign addr_ok     = HSEL_I && HTRANS_I[1] && HREADY_I;
	assign HREADYOUT_O = 1'b1;
	assign HRESP_O     = 1'b0;

	always_comb begin
		case (HADDR_I)
			`MPO_REG_CFG:   rd_mux = {25'h0, code};
			`MPO_REG_INTEG: rd_mux = {17'h0, adapt_secs, 6'h0, integ_mode};
			`MPO_REG_CTRL:  rd_mux = {30'h0, ctrl_state};
			`MPO_REG_STAT:  rd_mux = {26'h0, gen_busy, pair_out, pair_out};
			default:        rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge CLOCK_I) begin
		if (!NRST_I) begin
			wr_q     <= 1'b0;
			waddr_q  <= 32'h0;
			HRDATA_O <= 32'h0;
		end else if (CE_I) begin
			wr_q <= addr_ok && HWRITE_I;
			if (addr_ok) begin
				waddr_q <= HADDR_I;
			end
			if (addr_ok && !HWRITE_I) begin
				HRDATA_O <= rd_mux;
			end
		end
	end

	assign wr_cfg    = CE_I && wr_q && (waddr_q == `MPO_REG_CFG);
	assign wr_integ  = CE_I && wr_q && (waddr_q == `MPO_REG_INTEG);
	assign wr_ctrl   = CE_I && wr_q && (waddr_q == `MPO_REG_CTRL)
	                   && (code == `MPO_CODE_CTRL) && restored;
	assign next_ctrl = HWDATA_I[1:0];
	assign code_clr  = wr_cfg && (HWDATA_I[`MPO_CODE_MSB:0] != code);

	// ==========================================================
	// Configuration registers
	always_ff @(posedge CLOCK_I) begin
		if (!NRST_I) begin
			code <= `MPO_CODE_RST;
		end else if (wr_cfg) begin
			code <= HWDATA_I[`MPO_CODE_MSB:0];
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (!NRST_I) begin
			integ_mode <= INTEG_NORMAL;
			adapt_secs <= `MPO_SECS_RST;
		end else if (wr_integ) begin
			integ_mode <= mpo_integ_e'(HWDATA_I[`MPO_MODE_MSB:0]);
			if (HWDATA_I[`MPO_SECS_MSB:`MPO_SECS_LSB] < `MPO_INT_ADAPT_MIN) begin
				adapt_secs <= `MPO_INT_ADAPT_MIN;
			end else if (HWDATA_I[`MPO_SECS_MSB:`MPO_SECS_LSB]
			             > `MPO_INT_ADAPT_MAX) begin
				adapt_secs <= `MPO_INT_ADAPT_MAX;
			end else begin
				adapt_secs <= HWDATA_I[`MPO_SECS_MSB:`MPO_SECS_LSB];
			end
		end
	end

	// ==========================================================
	// Commanded state with non-volatile copy
	always_ff @(posedge CLOCK_I) begin
		if (!NRST_I) begin
			ctrl_state  <= 2'h0;
			restored    <= 1'b0;
			NVM_WR_O    <= 1'b0;
			NVM_WDATA_O <= 2'h0;
		end else if (CE_I) begin
			NVM_WR_O <= 1'b0;
			if (!restored) begin
				ctrl_state <= NVM_RDATA_I;
				restored   <= 1'b1;
			end else if (wr_ctrl) begin
				ctrl_state <= next_ctrl;
				if (next_ctrl != ctrl_state) begin
					NVM_WR_O    <= 1'b1;
					NVM_WDATA_O <= next_ctrl;
				end
			end
		end
	end

	// ==========================================================
	// Integration timebase
	logic [TCW-1:0] tick_cnt;
	logic           tick;
	logic [ICW-1:0] int_cnt;
	logic [ICW-1:0] int_target;
	logic [6:0]     int_secs;
	logic           integ_tick;

	assign tick = (tick_cnt == TCW'(TICK_CYCLES - 1));

	always_comb begin
		case (integ_mode)
			INTEG_NORMAL: int_secs = 7'(`MPO_INT_NORMAL_S);
			INTEG_FAST8:  int_secs = 7'(`MPO_INT_FAST8_S);
			INTEG_FAST2:  int_secs = 7'(`MPO_INT_FAST2_S);
			default:      int_secs = adapt_secs;
		endcase
		int_target = ICW'(32'(int_secs) * (`MPO_US_PER_S / `MPO_TICK_US));
	end

	assign integ_tick = CE_I && tick && (int_cnt >= int_target - ICW'(1));

	always_ff @(posedge CLOCK_I) begin
		if (!NRST_I) begin
			tick_cnt <= '0;
		end else if (CE_I) begin
			tick_cnt <= tick ? '0 : tick_cnt + TCW'(1);
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (!NRST_I) begin
			int_cnt <= '0;
		end else if (CE_I && tick) begin
			int_cnt <= integ_tick ? '0 : int_cnt + ICW'(1);
		end
	end

	// ==========================================================
	// Output pairs: index 0 is C, index 1 is D
	logic [1:0] div_cnt;
	logic       div_evt;

	assign div_evt = MTR_EVT_I.flow1 && (div_cnt == 2'(`MPO_DIV_RATIO - 1));

	always_ff @(posedge CLOCK_I) begin
		if (!NRST_I || code_clr) begin
			div_cnt <= 2'h0;
		end else if (CE_I && (mode == MODE_DIV) && MTR_EVT_I.flow1) begin
			div_cnt <= div_cnt + 2'h1;
		end
	end

	for (genvar i = 0; i < 2; i++) begin : pair
		logic          active;
		logic          evt;
		logic          step;
		logic [PW-1:0] acc;
		logic [PW-1:0] pend;
		logic [PW:0]   next_pend;
		logic [PW-1:0] add;
		logic          take;
		mpo_src_e      src;

		assign src = src_of(METER_FUNC, i);

		always_comb begin
			case (src)
				SRC_HEAT: step = MTR_EVT_I.heat_step;
				SRC_COOL: step = MTR_EVT_I.cool_step;
				default:  step = MTR_EVT_I.vol_step;
			endcase
			case (mode)
				MODE_TX: begin
					active = (i == 0) || (code == `MPO_CODE_TX2);
					evt    = (i == 0) ? MTR_EVT_I.flow1 : MTR_EVT_I.flow2;
				end
				MODE_DIV: begin
					active = (i == 0);
					evt    = (i == 0) && div_evt;
				end
				MODE_REG: begin
					active = 1'b1;
					evt    = 1'b0;
				end
				default: begin
					active = 1'b0;
					evt    = 1'b0;
				end
			endcase
			if (mode == MODE_REG) begin
				add = integ_tick ? acc : '0;
			end else begin
				add = (active && evt) ? PW'(1) : '0;
			end
			next_pend = {1'b0, pend} + {1'b0, add} - {PW'(0), take};
		end

		always_ff @(posedge CLOCK_I) begin
			if (!NRST_I || code_clr) begin
				acc <= '0;
			end else if (CE_I && (mode == MODE_REG)) begin
				if (integ_tick) begin
					acc <= step ? PW'(1) : '0;
				end else if (step && (acc != '1)) begin
					acc <= acc + PW'(1);
				end
			end
		end

		always_ff @(posedge CLOCK_I) begin
			if (!NRST_I || code_clr) begin
				pend <= '0;
			end else if (CE_I) begin
				pend <= next_pend[PW] ? '1 : next_pend[PW-1:0];
			end
		end

		mpo_pulse_gen #(
			.TW      (16)
		) u_gen (
			.clk_i   (CLOCK_I),
			.rst_n_i (NRST_I),
			.ce_i    (CE_I),
			.tick_i  (tick),
			.req_i   (active && (pend != '0)),
			.width_i (width),
			.take_o  (take),
			.busy_o  (gen_busy[i]),
			.out_o   (gen_out[i])
		);

		always_ff @(posedge CLOCK_I) begin
			if (!NRST_I) begin
				pair_out[i] <= 1'b0;
			end else if (CE_I) begin
				if (mode == MODE_CTRL) begin
					pair_out[i] <= ctrl_state[i];
				end else begin
					pair_out[i] <= active && gen_out[i];
				end
			end
		end
	end

	assign SLOT1_FIRST_OUTPUT_O  = pair_out[0];
	assign SLOT2_FIRST_OUTPUT_O  = pair_out[0];
	assign SLOT1_SECOND_OUTPUT_O = pair_out[1];
	assign SLOT2_SECOND_OUTPUT_O = pair_out[1];

	// ==========================================================
	// Checks
	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (!NRST_I);

	sequence seq_ctrl_change;
		wr_ctrl && restored && (next_ctrl != ctrl_state);
	endsequence

	sequence seq_burst_load;
		integ_tick && (mode == MODE_REG) && !code_clr
		&& (pair[0].acc != '0) && (pair[0].pend < 16'h0100);
	endsequence

	chk_slot_pairs: assert property (
		SLOT1_FIRST_OUTPUT_O == SLOT2_FIRST_OUTPUT_O
		&& SLOT1_SECOND_OUTPUT_O == SLOT2_SECOND_OUTPUT_O)
		else $error("slot outputs of one pair differ");

	chk_reset_code: assert property (disable iff (1'b0)
		!NRST_I |=> code == `MPO_CODE_RST && !SLOT1_FIRST_OUTPUT_O)
		else $error("configuration code not at reset value");

	chk_ctrl_follow: assert property (
		CE_I && (mode == MODE_CTRL) |=> pair_out == $past(ctrl_state))
		else $error("controlled outputs do not follow state");

	chk_nvm_store: assert property (
		seq_ctrl_change |=> NVM_WR_O && NVM_WDATA_O == $past(next_ctrl)
		&& ctrl_state == NVM_WDATA_O)
		else $error("state change not stored");

	chk_burst_load: assert property (
		seq_burst_load |=> pair[0].pend
		== $past(pair[0].pend) + $past(pair[0].acc) - 16'($past(pair[0].take)))
		else $error("accumulated count not loaded at integration");

	chk_d_idle_single: assert property (
		CE_I && (code == `MPO_CODE_TX1) |=> !SLOT1_SECOND_OUTPUT_O)
		else $error("second output active with single transmitter");

	chk_off_open: assert property (
		CE_I && (mode == MODE_OFF) |=> pair_out == 2'h0)
		else $error("output closed in an undriven mode");

	chk_div_every4: assert property (
		(mode == MODE_DIV) && pair[0].add != '0
		|-> MTR_EVT_I.flow1 && div_cnt == 2'(`MPO_DIV_RATIO - 1))
		else $error("divider pulse not on fourth flow pulse");

endmodule

// file: src/mpo_map.svh
// Register offsets, field positions, codes and timing figures
`ifndef MPO_MAP_SVH
`define MPO_MAP_SVH

// ==========================================================
// Register byte addresses
`define MPO_REG_CFG        32'h0000_0000
`define MPO_REG_INTEG      32'h0000_0004
`define MPO_REG_CTRL       32'h0000_0008
`define MPO_REG_STAT       32'h0000_000C

// ==========================================================
// Field positions
`define MPO_CODE_MSB       6
`define MPO_MODE_MSB       1
`define MPO_SECS_LSB       8
`define MPO_SECS_MSB       14
`define MPO_STAT_BUSY_LSB  4
`define MPO_STAT_BUSY_MSB  5

// ==========================================================
// Output configuration codes (decimal 73 80 82 83 94 95 96 99)
`define MPO_CODE_DIV5      7'h49
`define MPO_CODE_TX2       7'h50
`define MPO_CODE_TX1       7'h52
`define MPO_CODE_DIV22     7'h53
`define MPO_CODE_REG10     7'h5E
`define MPO_CODE_REG32     7'h5F
`define MPO_CODE_REG100    7'h60
`define MPO_CODE_CTRL      7'h63
`define MPO_CODE_RST       `MPO_CODE_REG32

// ==========================================================
// Timing figures
`define MPO_CLK_MHZ        200
`define MPO_TICK_US        100
`define MPO_US_PER_S       1000000
`define MPO_W_TX_US        3900
`define MPO_W_DIV5_US      5000
`define MPO_W_DIV22_US     22000
`define MPO_W_REG10_US     10000
`define MPO_W_REG32_US     32000
`define MPO_W_REG100_US    100000
`define MPO_INT_NORMAL_S   32
`define MPO_INT_FAST8_S    8
`define MPO_INT_FAST2_S    2
`define MPO_INT_ADAPT_MIN  7'h02
`define MPO_INT_ADAPT_MAX  7'h40
`define MPO_SECS_RST       7'h40
`define MPO_DIV_RATIO      4

`endif

// file: src/mpo_pkg.sv
// Types shared by the pulse output unit
package mpo_pkg;

	// ==========================================================
	// Output behaviour selected by the configuration code
	typedef enum logic [2:0] {
		MODE_TX,
		MODE_DIV,
		MODE_REG,
		MODE_CTRL,
		MODE_OFF
	} mpo_mode_e;

	// ==========================================================
	// Integration interval selection
	typedef enum logic [1:0] {
		INTEG_NORMAL,
		INTEG_FAST8,
		INTEG_FAST2,
		INTEG_ADAPT
	} mpo_integ_e;

	// ==========================================================
	// Meter function, fixed at delivery
	typedef enum logic [1:0] {
		FUNC_HEAT,
		FUNC_HEAT_COOL,
		FUNC_COOL,
		FUNC_VOLUME
	} mpo_func_e;

	// ==========================================================
	// Register counted on a pair
	typedef enum logic [1:0] {
		SRC_HEAT,
		SRC_COOL,
		SRC_VOL
	} mpo_src_e;

	// ==========================================================
	// Pulse generator states
	typedef enum logic [1:0] {
		GEN_IDLE,
		GEN_ON,
		GEN_GAP
	} mpo_gen_e;

	// ==========================================================
	// Meter events, each a one-cycle pulse
	typedef struct packed {
		logic flow1;
		logic flow2;
		logic heat_step;
		logic cool_step;
		logic vol_step;
	} mpo_evt_s;

endpackage

// file: src/mpo_pulse_gen.sv
// One pulse generator: a pulse of a set width followed by an equal gap
module mpo_pulse_gen
	import mpo_pkg::*;
#(
	parameter int TW = 16
) (
	// Clock, reset, enable and timebase
	input  wire logic          clk_i,
	input  wire logic          rst_n_i,
	input  wire logic          ce_i,
	input  wire logic          tick_i,
	// Request and width in ticks
	input  wire logic          req_i,
	input  wire logic [TW-1:0] width_i,
	// Status and output
	output logic               take_o,
	output logic               busy_o,
	output logic               out_o
);

	mpo_gen_e        st;
	logic [TW-1:0]   cnt;
	logic [TW-1:0]   wid;
	logic [TW-1:0]   hi_ticks;

	if (TW < 2) begin : g_bad_tw
		$error("pulse width counter too narrow");
	end

	assign take_o = ce_i && (st == GEN_IDLE) && req_i;
	assign busy_o = (st != GEN_IDLE);

	// ==========================================================
	// Pulse and gap timing
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st    <= GEN_IDLE;
			cnt   <= '0;
			wid   <= '0;
			out_o <= 1'b0;
		end else if (ce_i) begin
			case (st)
				GEN_IDLE: begin
					if (req_i) begin
						st    <= GEN_ON;
						out_o <= 1'b1;
						cnt   <= '0;
						wid   <= (width_i == '0) ? TW'(1) : width_i;
					end
				end
				GEN_ON: begin
					if (tick_i) begin
						if (cnt == wid) begin
							st    <= GEN_GAP;
							out_o <= 1'b0;
							cnt   <= '0;
						end else begin
							cnt <= cnt + TW'(1);
						end
					end
				end
				GEN_GAP: begin
					if (tick_i) begin
						if (cnt == wid) begin
							st <= GEN_IDLE;
						end else begin
							cnt <= cnt + TW'(1);
						end
					end
				end
				default: begin
					st    <= GEN_IDLE;
					out_o <= 1'b0;
				end
			endcase
		end
	end

	// ==========================================================
	// Checks
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || (take_o && !out_o)) begin
			hi_ticks <= '0;
		end else if (ce_i && out_o && tick_i) begin
			hi_ticks <= hi_ticks + TW'(1);
		end
	end

	chk_width_ticks: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$fell(out_o) |-> hi_ticks == wid + TW'(1))
		else $error("pulse width differs from programmed ticks");

	chk_gap_open: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(st == GEN_GAP) |-> !out_o ##1 (st != GEN_ON))
		else $error("output closed during gap");

endmodule

// file: tb/mpo_far_side.sv
// Far side model: pulse counter on the outputs and state store
module mpo_far_side
	import mpo_pkg::*;
(
	// Clock and statistics clear
	input  wire logic       clk_i,
	input  wire logic       clear_i,
	// Pulse outputs, high means closed
	input  wire logic       c1_i,
	input  wire logic       c2_i,
	input  wire logic       d1_i,
	input  wire logic       d2_i,
	// Non-volatile store
	input  wire logic       nvm_wr_i,
	input  wire logic [1:0] nvm_wdata_i,
	output logic      [1:0] nvm_rdata_o,
	// Statistics
	output int              cnt_c_o,
	output int              cnt_d_o,
	output int              hi_min_o,
	output int              hi_max_o,
	output int              gap_min_o,
	output int              nvm_cnt_o,
	output logic            pair_err_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic c_q = 1'b0;
	logic d_q = 1'b0;
	int   run;
	initial nvm_rdata_o = 2'h0;
	// ==========================================================
	// Count pulses and measure pulse and gap lengths
	always @(posedge clk_i) begin
		c_q <= c1_i;
		d_q <= d1_i;
		if (nvm_wr_i === 1'b1) begin
			nvm_rdata_o <= nvm_wdata_i;
		end
		if (clear_i) begin
			cnt_c_o <= 0;
			cnt_d_o <= 0;
			hi_min_o <= 32'h3FFF_FFFF;
			hi_max_o <= 0;
			gap_min_o <= 32'h3FFF_FFFF;
			nvm_cnt_o <= 0;
			pair_err_o <= 1'b0;
			run <= 0;
		end else begin
			if (c1_i !== c2_i || d1_i !== d2_i) pair_err_o <= 1'b1;
			if (d1_i === 1'b1 && d_q === 1'b0) cnt_d_o <= cnt_d_o + 1;
			if (nvm_wr_i === 1'b1) nvm_cnt_o <= nvm_cnt_o + 1;
			if (c1_i === c_q) begin
				run <= run + 1;
			end else begin
				run <= 0;
				if (c_q === 1'b1) begin
					if (run + 1 < hi_min_o) hi_min_o <= run + 1;
					if (run + 1 > hi_max_o) hi_max_o <= run + 1;
				end else begin
					cnt_c_o <= cnt_c_o + 1;
					if (cnt_c_o > 0 && run + 1 < gap_min_o) gap_min_o <= run + 1;
				end
			end
		end
	end
endmodule

// file: tb/tb.sv
// Testbench of the pulse output unit
`include "mpo_map.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import mpo_pkg::*;
	localparam int TC = 1;
	localparam logic [6:0] CODES [4] = '{`MPO_CODE_TX2, `MPO_CODE_TX1,
		`MPO_CODE_DIV5, `MPO_CODE_DIV22};
	localparam logic [6:0] RCODES [3] = '{`MPO_CODE_REG10, `MPO_CODE_REG32,
		`MPO_CODE_REG100};
	// ==========================================================
	// Signals
	logic        clk, nrst, hsel, hwrite, clr, hready, hresp, ce;
	logic        nvm_wr, c1, c2, d1, d2, perr;
	logic [1:0]  htrans, nvm_rd, nvm_wd;
	logic [31:0] haddr, hwdata, hrdata, rd;
	mpo_evt_s    evt;
	int          cnt_c, cnt_d, hi_min, hi_max, gap_min, nvm_cnt;
	int          num_errors, comparisons, n1, n2, w;
	mpo_top #(.TICK_CYCLES(TC)) mpo_top_i (
		.CLOCK_I(clk), .NRST_I(nrst), .CE_I(ce), .HSEL_I(hsel),
		.HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
		.HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
		.HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
		.MTR_EVT_I(evt), .NVM_RDATA_I(nvm_rd), .NVM_WR_O(nvm_wr),
		.NVM_WDATA_O(nvm_wd), .SLOT1_FIRST_OUTPUT_O(c1),
		.SLOT2_FIRST_OUTPUT_O(c2), .SLOT1_SECOND_OUTPUT_O(d1),
		.SLOT2_SECOND_OUTPUT_O(d2));
	mpo_far_side mpo_far_side_i (
		.clk_i(clk), .clear_i(clr), .c1_i(c1), .c2_i(c2), .d1_i(d1),
		.d2_i(d2), .nvm_wr_i(nvm_wr), .nvm_wdata_i(nvm_wd),
		.nvm_rdata_o(nvm_rd), .cnt_c_o(cnt_c), .cnt_d_o(cnt_d),
		.hi_min_o(hi_min), .hi_max_o(hi_max), .gap_min_o(gap_min),
		.nvm_cnt_o(nvm_cnt), .pair_err_o(perr));
	// ==========================================================
	// Expectations
	function automatic int width_of(logic [6:0] code);
		case (code)
			`MPO_CODE_TX2, `MPO_CODE_TX1: return 39;
			`MPO_CODE_DIV5: return 50;
			`MPO_CODE_DIV22: return 220;
			`MPO_CODE_REG10: return 100;
			`MPO_CODE_REG32: return 320;
			default: return 1000;
		endcase
	endfunction
	function automatic int exp_c(logic [6:0] code, int n);
		if (code == `MPO_CODE_DIV5 || code == `MPO_CODE_DIV22) return n / 4;
		return n;
	endfunction
	// ==========================================================
	// Compare, bus and event tasks
	task automatic check_val(string what, logic [31:0] exp, logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic check_rng(string what, int lo, int hi, int got);
		comparisons++;
		if (got < lo || got > hi) begin
			num_errors++;
			$display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo,
				hi, got);
		end
	endtask
	task automatic ahb(logic wr, logic [31:0] a, logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= a;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		rd = hrdata;
	endtask
	task automatic rd_chk(string what, logic [31:0] a, logic [31:0] exp);
		ahb(1'b0, a, 32'h0);
		check_val(what, exp, rd);
	endtask
	task automatic begin_test();
		@(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
	endtask
	task automatic send(mpo_evt_s e, int n);
		repeat (n) begin
			@(posedge clk);
			evt <= e;
			@(posedge clk);
			evt <= 5'h00;
			repeat ($urandom_range(3)) @(posedge clk);
		end
	endtask
	task automatic expect_out(string what, int ec, int ed, int wt, int lim);
		int k;
		k = 0;
		while ((cnt_c < ec || cnt_d < ed) && k < lim) begin
			@(posedge clk);
			k++;
		end
		check_val({what, " wait"}, 1'b1, cnt_c >= ec && cnt_d >= ed);
		repeat (4 * wt * TC + 20) @(posedge clk);
		check_val({what, " C count"}, ec, cnt_c);
		check_val({what, " D count"}, ed, cnt_d);
		check_val({what, " pairs"}, 1'b0, perr);
		if (ec > 0) check_rng({what, " width"}, wt * TC, wt * TC + TC, hi_min);
		if (ec > 0) check_rng({what, " width"}, wt * TC, wt * TC + TC, hi_max);
		if (ec > 1) check_rng({what, " gap"}, wt * TC, 32'h3FFF_FFFF, gap_min);
		$display("test %s done", what);
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// ==========================================================
	// Clock and watchdog
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		repeat (110000) @(posedge clk);
		num_errors++;
		$display("watchdog expired");
		complete_run();
	end
	// ==========================================================
	// Tests
	initial begin
		{nrst, hsel, hwrite, clr, htrans, haddr, hwdata} = '0;
		evt = 5'h00;
		ce = 1'b1;
		void'($urandom(98));
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		rd_chk("cfg reset", `MPO_REG_CFG, 32'h5F);
		rd_chk("integ reset", `MPO_REG_INTEG, 32'h4000);
		rd_chk("stat reset", `MPO_REG_STAT, 32'h0);
		rd_chk("unmapped", 32'h10, 32'h0);
		check_val("resp", 1'b0, hresp);
		foreach (CODES[i]) begin
			n1 = $urandom_range(4, 12);
			n2 = $urandom_range(1, 6);
			w = width_of(CODES[i]);
			begin_test();
			ahb(1'b1, `MPO_REG_CFG, CODES[i]);
			rd_chk("cfg", `MPO_REG_CFG, CODES[i]);
			send(5'h18, n2);
			send(5'h10, n1);
			expect_out("flow", exp_c(CODES[i], n1 + n2), CODES[i] ==
				`MPO_CODE_TX2 ? n2 : 0, w, 2 * w * TC * 20);
		end
		ahb(1'b1, `MPO_REG_INTEG, 32'h4002);
		rd_chk("integ", `MPO_REG_INTEG, 32'h4002);
		ahb(1'b1, `MPO_REG_INTEG, 32'h7F01);
		rd_chk("integ max", `MPO_REG_INTEG, 32'h4001);
		ahb(1'b1, `MPO_REG_INTEG, 32'h0103);
		rd_chk("integ min", `MPO_REG_INTEG, 32'h0203);
		foreach (RCODES[i]) begin
			n1 = $urandom_range(1, 3);
			n2 = $urandom_range(1, 3);
			begin_test();
			ahb(1'b1, `MPO_REG_CFG, RCODES[i]);
			send(5'h04, n1);
			send(5'h01, n2);
			send(5'h02, 2);
			w = width_of(RCODES[i]);
			expect_out("register", n1, n2, w, 50000);
		end
		begin_test();
		ahb(1'b1, `MPO_REG_CFG, 32'h00);
		send(5'h1F, 3);
		expect_out("invalid", 0, 0, 0, 0);
		ahb(1'b1, `MPO_REG_CFG, `MPO_CODE_CTRL);
		ahb(1'b1, `MPO_REG_CTRL, 32'h1);
		repeat (3) @(posedge clk);
		check_val("pins", 2'h1, {d1, c1});
		rd_chk("ctrl", `MPO_REG_CTRL, 32'h1);
		rd_chk("stat", `MPO_REG_STAT, 32'h5);
		ahb(1'b1, `MPO_REG_CTRL, 32'h1);
		ahb(1'b1, `MPO_REG_CTRL, 32'h2);
		repeat (3) @(posedge clk);
		check_val("pins", 2'h2, {d1, c1});
		check_val("stores", 2, nvm_cnt);
		check_val("stored", 2'h2, nvm_rd);
		ce <= 1'b0;
		ahb(1'b1, `MPO_REG_CTRL, 32'h1);
		repeat (3) @(posedge clk);
		check_val("frozen pins", 2'h2, {d1, c1});
		ce <= 1'b1;
		rd_chk("ctrl frozen", `MPO_REG_CTRL, 32'h2);
		@(posedge clk);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		rd_chk("ctrl restored", `MPO_REG_CTRL, 32'h2);
		ahb(1'b1, `MPO_REG_CTRL, 32'h1);
		rd_chk("ctrl locked", `MPO_REG_CTRL, 32'h2);
		check_val("pins", 2'h0, {d1, c1});
		ahb(1'b1, `MPO_REG_CFG, `MPO_CODE_CTRL);
		repeat (3) @(posedge clk);
		check_val("pins", 2'h2, {d1, c1});
		check_val("pairs", 1'b0, perr);
		$display("test controlled done");
		complete_run();
	end
endmodule
